// ---- single_wire_slave_signaling_crc_tb_top.sv ----
// Testbench joining master end and device end over the carrier.
// Assumes both ends share one 50 MHz clock; checks run at the user sides.
`define CHECK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
        end \
    end

module single_wire_slave_signaling_crc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import swire_pkg::*;

    logic       clk_sys = 1'b0, srst = 1'b1, req_valid = 1'b0;
    logic       req_bit = 1'b0, tx_enable = 1'b0, tx_bit = 1'b0;
    logic       rx_ready = 1'b0, crc_load = 1'b0, crc_shift_tx = 1'b0;
    logic [7:0] crc_seed = 8'h00;
    op_type     req_op = OP_RESET;
    logic       req_ready, done, result, tx_taken, rx_valid, bus_reset;
    logic       prog_strobe, overrun;
    logic [7:0] rx_byte, crc_value;
    int         failures = 0, num_checks = 0;
    int         n_reset = 0, n_taken = 0, n_prog = 0;

    swire_if bus_if ();
    swire_master i_swire_master (.CLK_SYS(clk_sys), .SRST(srst), .CE(1'b1),
        .BUS(bus_if), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_OP(req_op), .REQ_BIT(req_bit), .DONE(done), .RESULT(result));
    swire_device i_swire_device (.CLK_SYS(clk_sys), .SRST(srst), .CE(1'b1),
        .BUS(bus_if), .TX_ENABLE(tx_enable), .TX_BIT(tx_bit),
        .TX_TAKEN(tx_taken), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .RX_BYTE(rx_byte), .BUS_RESET(bus_reset), .PROG_STROBE(prog_strobe),
        .CRC_LOAD(crc_load), .CRC_SEED(crc_seed),
        .CRC_SHIFT_TX(crc_shift_tx), .CRC_VALUE(crc_value),
        .OVERRUN(overrun));
    swire_link_checker i_swire_link_checker (.CLK_SYS(clk_sys),
        .SRST(srst), .master_oe(bus_if.master_oe),
        .device_oe(bus_if.device_oe), .prog_hv(bus_if.prog_hv),
        .line(bus_if.line));

    always #10 clk_sys = ~clk_sys;

    // Pulses stand one cycle, so they are counted at every rising edge
    always @(posedge clk_sys) begin
        if (bus_reset === 1'b1) n_reset++;
        if (tx_taken === 1'b1) n_taken++;
        if (prog_strobe === 1'b1) n_prog++;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] crc_ref(logic [7:0] c, logic [7:0] d,
                                           int n);
        for (int i = 0; i < n; i++)
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction : crc_ref

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic do_op(input op_type op, input logic b);
        int t = 0;
        req_op    = op;
        req_bit   = b;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && t < 60000) begin
            step(1);
            t++;
        end
        step(1);
        req_valid = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 60000) begin
            step(1);
            t++;
        end
        `CHECK("op done", 1'b1, done)
    endtask : do_op

    task automatic load_crc(input logic [7:0] seed);
        crc_seed = seed;
        crc_load = 1'b1;
        step(1);
        crc_load = 1'b0;
        step(1);
        `CHECK("crc load", seed, crc_value)
    endtask : load_crc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_presence();
        do_op(OP_RESET, 1'b0);
        `CHECK("presence", 1'b1, result)
        `CHECK("reset pulses", 1, n_reset)
    endtask : test_reset_presence

    // Receiver stalls so the byte must stand until taken
    task automatic test_write_byte(input logic [7:0] d);
        load_crc(8'h3C);
        for (int i = 0; i < 8; i++)
            do_op(OP_WRITE, d[i]);
        step(20);
        `CHECK("rx valid held", 1'b1, rx_valid)
        `CHECK("rx byte", d, rx_byte)
        `CHECK("write crc", crc_ref(8'h3C, d, 8), crc_value)
        rx_ready = 1'b1;
        step(1);
        rx_ready = 1'b0;
        step(2);
        `CHECK("rx drained", 1'b0, rx_valid)
        `CHECK("overrun", 1'b0, overrun)
    endtask : test_write_byte

    task automatic test_read_bits();
        load_crc(8'h81);
        crc_shift_tx = 1'b1;
        tx_enable    = 1'b1;
        tx_bit       = 1'b0;
        do_op(OP_READ, 1'b1);
        `CHECK("read zero", 1'b0, result)
        tx_bit = 1'b1;
        do_op(OP_READ, 1'b1);
        `CHECK("read one", 1'b1, result)
        `CHECK("bits taken", 2, n_taken)
        `CHECK("read crc", crc_ref(8'h81, 8'h02, 2), crc_value)
        tx_enable    = 1'b0;
        crc_shift_tx = 1'b0;
    endtask : test_read_bits

    task automatic test_prog();
        do_op(OP_PROG, 1'b0);
        step(2);
        `CHECK("prog strobes", 1, n_prog)
        `CHECK("idle line", 1'b1, bus_if.line)
    endtask : test_prog

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        test_reset_presence();
        test_write_byte(8'hA6);
        test_read_bits();
        test_prog();
        end_of_test();
    end

    // Run needs about 110k cycles; a little margin before giving up
    initial begin
        #(125000 * 20);
        failures++;
        end_of_test();
    end
endmodule : single_wire_slave_signaling_crc_tb_top

// ---- swire_device.sv ----
// Device end: reset/presence detection, slot timing, program pulse and CRC.
// Assumes line is synchronous to CLK_SYS; one master drives all slots.
// Received bits assemble into bytes and pass through a 32-word FIFO; the
// user side supplies the next read bit and CRC control.
module swire_device
    import swire_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 32
) (
    input  wire logic       CLK_SYS,
    input  wire logic       SRST,
    input  wire logic       CE,
    swire_if.device         BUS,
    input  wire logic       TX_ENABLE,   // Next slots are read slots
    input  wire logic       TX_BIT,      // Bit to send in next read slot
    output logic            TX_TAKEN,    // Pulse: TX_BIT consumed
    output logic            RX_VALID,
    input  wire logic       RX_READY,
    output logic [7:0]      RX_BYTE,
    output logic            BUS_RESET,   // Pulse: reset seen
    output logic            PROG_STROBE, // Pulse: program pulse ended
    input  wire logic       CRC_LOAD,    // Preload CRC with CRC_SEED
    input  wire logic [7:0] CRC_SEED,
    input  wire logic       CRC_SHIFT_TX, // Include sent bits in CRC
    output logic [7:0]      CRC_VALUE,
    output logic            OVERRUN
);
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_LOW    = 3'b001,
        S_WAITP  = 3'b010,
        S_PRES   = 3'b011,
        S_HOLD0  = 3'b100
    } state_type;

    state_type        st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             line_q, sampled_q, sampled_d, tx_q, tx_d;
    logic [7:0]       sh_q, sh_d, crc_q, crc_d;
    logic [2:0]       nb_q, nb_d;
    logic             oe_q, oe_d, push, ovr_q, ovr_d, in_ready;
    logic             rst_p, prog_p, taken;
    logic             fall;

    assign fall = line_q & ~BUS.line & ~BUS.prog_hv;

    always_comb begin
        st_d = st_q;  cnt_d = cnt_q + 1'b1;  oe_d = oe_q;
        sampled_d = sampled_q;  tx_d = tx_q;  sh_d = sh_q;  nb_d = nb_q;
        crc_d = crc_q;  push = 1'b0;  ovr_d = ovr_q;
        rst_p = 1'b0;  taken = 1'b0;
        if (CRC_LOAD) crc_d = CRC_SEED;
        case (st_q)
            S_IDLE: begin
                if (fall) begin
                    st_d = S_LOW;  cnt_d = '0;  sampled_d = 1'b0;
                    tx_d = TX_BIT;
                    if (TX_ENABLE) begin
                        taken = 1'b1;
                        oe_d  = ~TX_BIT;
                        if (!TX_BIT) st_d = S_HOLD0;
                    end
                end
            end
            S_HOLD0: begin
                // Hold zero past read-valid, release within margin
                if (cnt_q >= us_cycles(READ_VALID_TIME + ZERO_RELEASE_TIME))
                begin
                    oe_d = 1'b0;  st_d = S_LOW;  sampled_d = 1'b1;
                    if (CRC_SHIFT_TX) begin
                        crc_d = crc_step(crc_d, tx_q);
                    end
                end
            end
            S_LOW: begin
                if (!sampled_q && cnt_q == us_cycles(WRITE_SAMPLE_TIME))
                begin
                    sampled_d = 1'b1;
                    if (!TX_ENABLE || !tx_q) begin
                        sh_d  = {BUS.line, sh_q[7:1]};
                        crc_d = crc_step(crc_d, BUS.line);
                        nb_d  = nb_q + 1'b1;
                        if (nb_q == 3'd7) begin
                            push  = 1'b1;
                            ovr_d = ovr_q | ~in_ready;
                        end
                    end else if (CRC_SHIFT_TX) begin
                        crc_d = crc_step(crc_d, tx_q);
                    end
                end
                if (BUS.line) begin
                    // Long low ending here is a reset; a write one rises
                    // early, so stay until the sample point has passed
                    if (cnt_q >= us_cycles(RESET_DETECT_TIME)) begin
                        st_d = S_WAITP;  cnt_d = '0;
                    end else if (sampled_d) begin
                        st_d = S_IDLE;
                    end
                end else if (cnt_q >= us_cycles(RESET_DETECT_TIME)) begin
                    st_d = S_WAITP;  // Wait for rising edge, then presence
                end
            end
            S_WAITP: begin
                if (!BUS.line) cnt_d = '0;
                else if (cnt_q == us_cycles(PRESENCE_WAIT_TIME)) begin
                    st_d = S_PRES;  oe_d = 1'b1;  cnt_d = '0;
                    rst_p = 1'b1;  nb_d = '0;  crc_d = CRC_INIT;
                end
            end
            S_PRES: begin
                if (cnt_q == us_cycles(PRESENCE_LOW_TIME)) begin
                    oe_d = 1'b0;  st_d = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st_q <= S_IDLE;  cnt_q <= '0;  line_q <= 1'b1;  oe_q <= 1'b0;
            sampled_q <= 1'b0;  tx_q <= 1'b1;  sh_q <= '0;  nb_q <= '0;
            crc_q <= CRC_INIT;  ovr_q <= 1'b0;
            BUS_RESET <= 1'b0;  PROG_STROBE <= 1'b0;  TX_TAKEN <= 1'b0;
        end else if (CE) begin
            st_q <= st_d;  cnt_q <= cnt_d;  line_q <= BUS.line;
            oe_q <= oe_d;  sampled_q <= sampled_d;  tx_q <= tx_d;
            sh_q <= sh_d;  nb_q <= nb_d;  crc_q <= crc_d;  ovr_q <= ovr_d;
            BUS_RESET <= rst_p;
            PROG_STROBE <= prog_p;
            TX_TAKEN <= taken;
        end
    end

    logic hv_q;
    assign prog_p = hv_q & ~BUS.prog_hv;
    always_ff @(posedge CLK_SYS) begin
        if (SRST) hv_q <= 1'b0;
        else if (CE) hv_q <= BUS.prog_hv;
    end

    assign BUS.device_oe = oe_q;
    assign CRC_VALUE     = crc_q;
    assign OVERRUN       = ovr_q;

    swire_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .clk       (CLK_SYS),
        .srst      (SRST),
        .ce        (CE),
        .in_valid  (push),
        .in_ready  (in_ready),
        .in_data   ({BUS.line, sh_q[7:1]}),
        .out_valid (RX_VALID),
        .out_ready (RX_READY),
        .out_data  (RX_BYTE)
    );
endmodule : swire_device

// ---- swire_fifo.sv ----
// Parameterised valid/ready FIFO used on the device's received-byte path.
// Assumes a single clock and synchronous active-high reset.
module swire_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    always_comb begin
        wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d  = pop  ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = (AW+1)'(cnt_q + push - pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem[wp_q] <= in_data;
            end
        end
    end
endmodule : swire_fifo

// ---- swire_if.sv ----
// Carrier joining master end and device end over one open-drain line.
// Assumes an external pull-up: the line reads high unless someone drives.
interface swire_if;
    logic master_oe;  // High while master pulls line low
    logic device_oe;  // High while device pulls line low
    logic prog_hv;    // High while master applies program voltage
    logic line;

    assign line = ~(master_oe | device_oe);

    modport master (output master_oe, output prog_hv, input line);
    modport device (output device_oe, input prog_hv, input line);
endinterface : swire_if

// ---- swire_link_checker.sv ----
// Concurrent checks on the shared single-wire line, both ends attached.
// Assumes the carrier's signals as plain inputs and one 50 MHz clock.
module swire_link_checker (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic master_oe,
    input wire logic device_oe,
    input wire logic prog_hv,
    input wire logic line
);
    localparam int RST_MIN = 24000;
    localparam int RST_MAX = 48000;
    localparam int PW_MIN  = 750;
    localparam int PW_MAX  = 3000;

    logic [15:0] mlow_q, mlow_d, dlow_q, dlow_d;
    logic [15:0] high_q, high_d, pp_q, pp_d, slot_q, slot_d;
    logic        pres_q, pres_d;
    logic [15:0] pw_q, pw_d;

    // ------------------------------------------------------------
    // Width counters
    // ------------------------------------------------------------
    // Saturating, so a long idle never wraps into a legal width
    function automatic logic [15:0] bump(logic on, logic [15:0] c);
        return on ? ((c == 16'hFFFF) ? c : c + 16'h0001) : 16'h0000;
    endfunction : bump

    always_comb begin
        mlow_d = bump(master_oe, mlow_q);
        dlow_d = bump(device_oe, dlow_q);
        high_d = bump(line, high_q);
        pp_d   = bump(prog_hv, pp_q);
        slot_d = (master_oe && mlow_q == 16'h0000) ? 16'h0000
                                                   : bump(1'b1, slot_q);
        pres_d = (device_oe && dlow_q == 16'h0000) ? !master_oe : pres_q;
        // Time since a reset pulse ended, until presence starts
        if (!master_oe && mlow_q >= RST_MIN) begin
            pw_d = 16'h0001;
        end else if (device_oe && dlow_q == 16'h0000) begin
            pw_d = 16'h0000;
        end else begin
            pw_d = (pw_q == 16'h0000) ? pw_q : bump(1'b1, pw_q);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            mlow_q <= 16'h0000;
            dlow_q <= 16'h0000;
            pp_q   <= 16'h0000;
            high_q <= 16'hFFFF;
            slot_q <= 16'hFFFF;
            pres_q <= 1'b0;
            pw_q   <= 16'h0000;
        end else begin
            mlow_q <= mlow_d;
            dlow_q <= dlow_d;
            pp_q   <= pp_d;
            high_q <= high_d;
            slot_q <= slot_d;
            pres_q <= pres_d;
            pw_q   <= pw_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    sequence presence_start;
        $rose(device_oe) && !master_oe;
    endsequence

    a_presence_wait: assert property (
        presence_start |-> pw_q inside {[PW_MIN:PW_MAX]})
        else $error("presence did not follow reset in time");
    a_presence_due: assert property (
        pw_q <= PW_MAX)
        else $error("presence missing after reset");
    a_low_width: assert property (
        $fell(master_oe) |->
            mlow_q inside {[50:749], [3000:5999], [RST_MIN:RST_MAX]})
        else $error("master low time out of range");
    a_presence_len: assert property (
        $fell(device_oe) && pres_q |-> dlow_q inside {[3000:12000]})
        else $error("presence pulse width out of range");
    a_zero_hold: assert property (
        $fell(device_oe) && !pres_q |-> dlow_q inside {[749:2999]})
        else $error("read zero released too early or too late");
    a_slot_len: assert property (
        $rose(master_oe) |-> slot_q >= 3050)
        else $error("slot shorter than minimum");
    a_slot_recovery: assert property (
        $rose(master_oe) |-> high_q >= 50)
        else $error("recovery time too short");
    a_prog_quiet: assert property (
        prog_hv |-> !master_oe && !device_oe)
        else $error("line pulled low during program pulse");
    a_prog_idle: assert property (
        $rose(prog_hv) |-> line && high_q >= 50)
        else $error("program pulse not from idle");
    a_prog_width: assert property (
        $fell(prog_hv) |-> pp_q >= RST_MIN)
        else $error("program pulse too short");
    a_device_origin: assert property (
        $rose(device_oe) |-> master_oe || high_q inside {[750:3000]})
        else $error("device drove line unprompted");
endmodule : swire_link_checker

// ---- swire_master.sv ----
// Master end: issues reset, write, read and program operations.
// Assumes one command at a time through a valid/ready request port.
module swire_master
    import swire_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       SRST,
    input  wire logic       CE,
    swire_if.master         BUS,
    input  wire logic       REQ_VALID,
    output logic            REQ_READY,
    input  wire op_type     REQ_OP,
    input  wire logic       REQ_BIT,
    output logic            DONE,      // Pulse: operation finished
    output logic            RESULT     // Presence seen or bit read
);
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_RST  = 3'b001,
        M_RWT  = 3'b010,
        M_SLOT = 3'b011,
        M_PROG = 3'b100,
        M_REC  = 3'b101
    } mstate_type;

    mstate_type       st_q, st_d;
    op_type           op_q, op_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, low_q, low_d;
    logic             oe_q, oe_d, hv_q, hv_d, res_q, res_d, bit_q, bit_d;
    logic             done_d;

    assign REQ_READY = (st_q == M_IDLE);

    always_comb begin
        st_d = st_q;  op_d = op_q;  cnt_d = cnt_q + 1'b1;  low_d = low_q;
        oe_d = oe_q;  hv_d = hv_q;  res_d = res_q;  bit_d = bit_q;
        done_d = 1'b0;
        case (st_q)
            M_IDLE: begin
                oe_d = 1'b0;  hv_d = 1'b0;
                if (REQ_VALID) begin
                    op_d = REQ_OP;  bit_d = REQ_BIT;  cnt_d = '0;
                    case (REQ_OP)
                        OP_RESET: begin oe_d = 1'b1;  st_d = M_RST; end
                        OP_PROG:  begin hv_d = 1'b1;  st_d = M_PROG; end
                        default: begin
                            oe_d = 1'b1;  st_d = M_SLOT;
                            low_d = (REQ_OP == OP_READ)
                                  ? us_cycles(READ_OPEN_LOW_TIME)
                                  : (REQ_BIT ? us_cycles(READ_OPEN_LOW_TIME)
                                    : us_cycles(WRITE_ZERO_LOW_TIME));
                        end
                    endcase
                end
            end
            M_RST: begin
                if (cnt_q == us_cycles(RESET_LOW_TIME)) begin
                    oe_d = 1'b0;  cnt_d = '0;  res_d = 1'b0;
                    st_d = M_RWT;
                end
            end
            M_RWT: begin
                if (!BUS.line) res_d = 1'b1;
                if (cnt_q == us_cycles(RESET_LOW_TIME)) begin
                    st_d = M_IDLE;  done_d = 1'b1;
                end
            end
            M_SLOT: begin
                if (cnt_q == low_q) oe_d = 1'b0;
                if (op_q == OP_READ && cnt_q == us_cycles(MASTER_SAMPLE_TIME))
                    res_d = BUS.line;
                if (cnt_q == us_cycles(BIT_SLOT_LENGTH)) begin
                    cnt_d = '0;  st_d = M_REC;
                end
            end
            M_PROG: begin
                if (cnt_q == us_cycles(PROGRAM_PULSE_TIME)) begin
                    hv_d = 1'b0;  cnt_d = '0;  st_d = M_REC;
                end
            end
            M_REC: begin
                if (cnt_q == us_cycles(SLOT_RECOVERY_TIME)) begin
                    st_d = M_IDLE;  done_d = 1'b1;
                end
            end
            default: st_d = M_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st_q <= M_IDLE;  op_q <= OP_RESET;  cnt_q <= '0;  low_q <= '0;
            oe_q <= 1'b0;  hv_q <= 1'b0;  res_q <= 1'b0;  bit_q <= 1'b0;
            DONE <= 1'b0;
        end else if (CE) begin
            st_q <= st_d;  op_q <= op_d;  cnt_q <= cnt_d;  low_q <= low_d;
            oe_q <= oe_d;  hv_q <= hv_d;  res_q <= res_d;  bit_q <= bit_d;
            DONE <= done_d;
        end
    end

    assign BUS.master_oe = oe_q;
    assign BUS.prog_hv   = hv_q;
    assign RESULT        = res_q;
endmodule : swire_master

// ---- swire_pkg.sv ----
// Shared constants for the single-wire signaling layer, both ends.
// Assumes one 50 MHz clock at each end and a wired-AND line resolved in
// the interface from the two output enables.
package swire_pkg;
    localparam int unsigned CLK_MHZ            = 50;
    localparam int unsigned RESET_LOW_TIME     = 480;  // us
    localparam int unsigned RESET_DETECT_TIME  = 480;  // us
    localparam int unsigned PRESENCE_WAIT_TIME = 30;   // us, within 15-60
    localparam int unsigned PRESENCE_LOW_TIME  = 120;  // us, within 60-240
    localparam int unsigned BIT_SLOT_LENGTH    = 70;   // us, 60 to <120
    localparam int unsigned WRITE_ZERO_LOW_TIME = 65;  // us
    localparam int unsigned READ_OPEN_LOW_TIME = 2;    // us, 1 to <15
    localparam int unsigned READ_VALID_TIME    = 15;   // us
    localparam int unsigned ZERO_RELEASE_TIME  = 15;   // us, <45
    localparam int unsigned SLOT_RECOVERY_TIME = 5;    // us
    localparam int unsigned WRITE_SAMPLE_TIME  = 30;   // us
    localparam int unsigned MASTER_SAMPLE_TIME = 12;   // us, before 15
    localparam int unsigned PROGRAM_PULSE_TIME = 480;  // us
    localparam int unsigned CNT_W              = 16;
    localparam logic [7:0]  CRC_POLY           = 8'h8C; // reflected
    localparam logic [7:0]  CRC_INIT           = 8'h00;

    function automatic logic [CNT_W-1:0] us_cycles(input int unsigned us);
        us_cycles = CNT_W'(us * CLK_MHZ);
    endfunction : us_cycles

    // One bit of the reflected CRC, LSB first on the wire
    function automatic logic [7:0] crc_step(input logic [7:0] crc,
                                            input logic       bit_in);
        logic fb;
        fb = crc[0] ^ bit_in;
        crc_step = (crc >> 1) ^ (fb ? CRC_POLY : 8'h00);
    endfunction : crc_step

    typedef enum logic [1:0] {
        OP_RESET = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ  = 2'b10,
        OP_PROG  = 2'b11
    } op_type;
endpackage : swire_pkg
